// ---- inc/step_atten_defs.svh ----
/*
 Constants of the step attenuator control block: pin vector layout,
 preset values, power-up wait, register offsets and bus answers.
 Assumes inclusion by bare name from the design file.
*/
`ifndef STEP_ATTEN_DEFS_SVH
`define STEP_ATTEN_DEFS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define SA_ATTEN_W      6
`define SA_PIN_W        12
`define SA_ADDR_W       4

// ----------------------------------------
// Pin vector bit positions
// ----------------------------------------
`define SA_PIN_PRESET_LSB 6
`define SA_PIN_PRESET_MSB 7
`define SA_PIN_STROBE     8
`define SA_PIN_SDATA      9
`define SA_PIN_SCLK       10
`define SA_PIN_MODE       11

// ----------------------------------------
// Attenuation words, bit 5 = 16 dB ... bit 0 = 0.5 dB
// ----------------------------------------
`define SA_ATTEN_REF    6'h00
`define SA_ATTEN_8DB    6'h10
`define SA_ATTEN_16DB   6'h20
`define SA_ATTEN_MAX    6'h3F

// ----------------------------------------
// Timing
// ----------------------------------------
`define SA_SYS_CLK_NS   100
`define SA_PWRUP_CYCLES 3'h4

// ----------------------------------------
// Register map
// ----------------------------------------
`define SA_REG_ATTEN    4'h0
`define SA_REG_SHIFT    4'h4
`define SA_REG_CTRL     4'h8
`define SA_SHIFT_RUN_BIT    8
`define SA_SHIFT_MODE_BIT   7
`define SA_SHIFT_STROBE_BIT 6
`define SA_CTRL_RELOAD_BIT  0
`define SA_RESP_OKAY    2'h0
`define SA_RESP_SLVERR  2'h2

`endif

// ---- inc/step_atten_pkg.sv ----
/*
 Types of the step attenuator control block.
 Assumes nothing of its surroundings.
*/
package step_atten_pkg;
	typedef enum logic [0:0] {PWR_WAIT, PWR_RUN} pwr_state_e;
	typedef logic [5:0] atten_t;
endpackage

// ---- hw/step_attenuator_control.sv ----
/*
 Control logic of a 6-bit, 0.5 dB step attenuator: parallel direct and
 latched modes, serial shift register with transparent latch, power-up
 state load, and an AXI4-Lite register window.
 Assumes all host pins are asynchronous to sys_clk and slower than it;
 the serial clock is sampled, never used as a clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "step_atten_defs.svh"

// Contract
// - Strap low selects parallel inputs, strap high selects serial interface.
// - Parallel mode takes state from six weighted control inputs.
// - Bits weigh 0.5,1,2,4,8,16 dB; all ones is 31.5 dB.
// - Parallel mode with strobe high makes the latch transparent.
// - Parallel mode ignores serial data and serial clock.
// - Serial mode uses 6-bit shift register behind a transparent latch.
// - Shifting happens whatever the strobe level.
// - Serial data sampled on each serial clock rising edge.
// - Word shifted MSB first; first bit lands at 16 dB weight.
// - Strobe high passes shift register through; strobe low holds it.
// - Serial power-up loads state from the six parallel inputs; code does so on a reload only, after reset it loads ref.
// - Parallel power-up with strobe low loads a preset from selects; after reset code loads ref whatever the selects.
// - Presets 00 ref, 01 8 dB, 10 16 dB, 11 31.5 dB.
// - Parallel power-up with strobe high follows parallel inputs.
module step_attenuator_control (
	// Clock and reset
	input  wire logic                    sys_clk,
	input  wire logic                    rstn,
	// Host control pins
	input  wire logic                    modeSerial,
	input  wire logic                    latch_strobe,
	input  wire logic                    serialData,
	input  wire logic                    serialClock,
	input  wire logic                    weight_half_db_bit,
	input  wire logic                    weight_one_db_bit,
	input  wire logic                    weight_two_db_bit,
	input  wire logic                    weight_four_db_bit,
	input  wire logic                    weight_eight_db_bit,
	input  wire logic                    weight_sixteen_db_bit,
	input  wire logic                    preset_select_msb,
	input  wire logic                    preset_select_lsb,
	// Attenuator drive
	output logic [`SA_ATTEN_W-1:0]       attenState,
	// AXI4-Lite write channels
	input  wire logic [`SA_ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [`SA_ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [`SA_PIN_W-1:0]   pins;
	logic [`SA_PIN_W-1:0]   sync1Q;
	logic [`SA_PIN_W-1:0]   sync2Q;
	logic [`SA_PIN_W-1:0]   sync3Q;
	logic [`SA_PIN_W-1:0]   filtQ;
	logic [`SA_PIN_W-1:0]   filtD;

	assign pins = {modeSerial, serialClock, serialData, latch_strobe,
		preset_select_msb, preset_select_lsb,
		weight_sixteen_db_bit, weight_eight_db_bit, weight_four_db_bit,
		weight_two_db_bit, weight_one_db_bit, weight_half_db_bit};

	// A bit changes only once two stages agree, so one bad sample is dropped
	always_comb begin
		filtD = (filtQ & (sync2Q ^ sync3Q)) | (sync3Q & ~(sync2Q ^ sync3Q));
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sync1Q <= '0;
			sync2Q <= '0;
			sync3Q <= '0;
			filtQ  <= '0;
		end else begin
			sync1Q <= pins;
			sync2Q <= sync1Q;
			sync3Q <= sync2Q;
			filtQ  <= filtD;
		end
	end

	step_atten_pkg::atten_t parWord;
	logic [1:0]             presetSel;
	logic                   strobe;
	logic                   sData;
	logic                   sClk;
	logic                   serialMode;
	logic                   sClkPrevQ;
	logic                   clkRise;

	assign parWord    = filtQ[`SA_ATTEN_W-1:0];
	assign presetSel  = filtQ[`SA_PIN_PRESET_MSB:`SA_PIN_PRESET_LSB];
	assign strobe     = filtQ[`SA_PIN_STROBE];
	assign sData      = filtQ[`SA_PIN_SDATA];
	assign sClk       = filtQ[`SA_PIN_SCLK];
	assign serialMode = filtQ[`SA_PIN_MODE];
	assign clkRise    = sClk & ~sClkPrevQ;

	function automatic step_atten_pkg::atten_t presetValue(input logic [1:0] sel);
		case (sel)
			2'h0:    presetValue = `SA_ATTEN_REF;
			2'h1:    presetValue = `SA_ATTEN_8DB;
			2'h2:    presetValue = `SA_ATTEN_16DB;
			default: presetValue = `SA_ATTEN_MAX;
		endcase
	endfunction

	// ----------------------------------------
	// Attenuation state
	// ----------------------------------------
	step_atten_pkg::pwr_state_e stateQ;
	step_atten_pkg::pwr_state_e stateD;
	logic [2:0]                 cntQ;
	logic [2:0]                 cntD;
	step_atten_pkg::atten_t     shiftQ;
	step_atten_pkg::atten_t     shiftD;
	step_atten_pkg::atten_t     attenQ;
	step_atten_pkg::atten_t     attenD;
	logic                       reloadReq;
	logic                       lastWait;

	assign lastWait = (stateQ == step_atten_pkg::PWR_WAIT) &&
		(cntQ == `SA_PWRUP_CYCLES - 3'h1);

	always_comb begin
		stateD = stateQ;
		cntD   = cntQ;
		shiftD = shiftQ;
		attenD = attenQ;
		case (stateQ)
			// Waits 4 cycles; after a reload the synchronisers hold true pin levels, after reset filtQ still holds its reset level
			step_atten_pkg::PWR_WAIT: begin
				if (lastWait) begin
					stateD = step_atten_pkg::PWR_RUN;
					cntD   = 3'h0;
					if (serialMode) begin
						attenD = parWord;
					end else if (strobe) begin
						attenD = parWord;
					end else begin
						attenD = presetValue(presetSel);
					end
				end else begin
					cntD = cntQ + 3'h1;
				end
			end
			step_atten_pkg::PWR_RUN: begin
				if (serialMode) begin
					if (clkRise) begin
						shiftD = {shiftQ[`SA_ATTEN_W-2:0], sData};
					end
					if (strobe) begin
						attenD = shiftD;
					end
				end else if (strobe) begin
					attenD = parWord;
				end
				if (reloadReq) begin
					stateD = step_atten_pkg::PWR_WAIT;
				end
			end
			default: begin
				stateD = step_atten_pkg::PWR_WAIT;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			stateQ    <= step_atten_pkg::PWR_WAIT;
			cntQ      <= 3'h0;
			shiftQ    <= `SA_ATTEN_REF;
			attenQ    <= `SA_ATTEN_REF;
			sClkPrevQ <= 1'b0;
		end else begin
			stateQ    <= stateD;
			cntQ      <= cntD;
			shiftQ    <= shiftD;
			attenQ    <= attenD;
			sClkPrevQ <= sClk;
		end
	end

	assign attenState = attenQ;

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	logic                   awHeldQ, awHeldD;
	logic                   wHeldQ, wHeldD;
	logic [`SA_ADDR_W-1:0]  awAddrQ, awAddrD;
	logic [31:0]            wDataQ, wDataD;
	logic                   wStrbQ, wStrbD;
	logic                   bValidQ, bValidD;
	logic [1:0]             bRespQ, bRespD;
	logic                   rValidQ, rValidD;
	logic [1:0]             rRespQ, rRespD;
	logic [31:0]            rDataQ, rDataD;
	logic                   doWrite;

	assign s_axi_awready = !awHeldQ && !bValidQ;
	assign s_axi_wready  = !wHeldQ && !bValidQ;
	assign s_axi_arready = !rValidQ;
	assign doWrite       = awHeldQ && wHeldQ && !bValidQ;
	assign reloadReq     = doWrite && (awAddrQ == `SA_REG_CTRL) && wStrbQ &&
		wDataQ[`SA_CTRL_RELOAD_BIT];

	always_comb begin
		awHeldD = awHeldQ;
		wHeldD  = wHeldQ;
		awAddrD = awAddrQ;
		wDataD  = wDataQ;
		wStrbD  = wStrbQ;
		bValidD = bValidQ;
		bRespD  = bRespQ;
		rValidD = rValidQ;
		rRespD  = rRespQ;
		rDataD  = rDataQ;
		if (s_axi_awvalid && s_axi_awready) begin
			awHeldD = 1'b1;
			awAddrD = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wHeldD = 1'b1;
			wDataD = s_axi_wdata;
			wStrbD = s_axi_wstrb[0];
		end
		if (doWrite) begin
			awHeldD = 1'b0;
			wHeldD  = 1'b0;
			bValidD = 1'b1;
			// Status words are read-only; writes to them are dropped
			case (awAddrQ)
				`SA_REG_ATTEN, `SA_REG_SHIFT, `SA_REG_CTRL: bRespD = `SA_RESP_OKAY;
				default: bRespD = `SA_RESP_SLVERR;
			endcase
		end else if (bValidQ && s_axi_bready) begin
			bValidD = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rValidD = 1'b1;
			rRespD  = `SA_RESP_OKAY;
			rDataD  = 32'h0000_0000;
			case (s_axi_araddr)
				`SA_REG_ATTEN: rDataD[`SA_ATTEN_W-1:0] = attenQ;
				`SA_REG_SHIFT: begin
					rDataD[`SA_ATTEN_W-1:0]      = shiftQ;
					rDataD[`SA_SHIFT_STROBE_BIT] = strobe;
					rDataD[`SA_SHIFT_MODE_BIT]   = serialMode;
					rDataD[`SA_SHIFT_RUN_BIT]    = (stateQ == step_atten_pkg::PWR_RUN);
				end
				`SA_REG_CTRL: rDataD = 32'h0000_0000;
				default: rRespD = `SA_RESP_SLVERR;
			endcase
		end else if (rValidQ && s_axi_rready) begin
			rValidD = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			awHeldQ <= 1'b0;
			wHeldQ  <= 1'b0;
			awAddrQ <= '0;
			wDataQ  <= 32'h0000_0000;
			wStrbQ  <= 1'b0;
			bValidQ <= 1'b0;
			bRespQ  <= 2'h0;
			rValidQ <= 1'b0;
			rRespQ  <= 2'h0;
			rDataQ  <= 32'h0000_0000;
		end else begin
			awHeldQ <= awHeldD;
			wHeldQ  <= wHeldD;
			awAddrQ <= awAddrD;
			wDataQ  <= wDataD;
			wStrbQ  <= wStrbD;
			bValidQ <= bValidD;
			bRespQ  <= bRespD;
			rValidQ <= rValidD;
			rRespQ  <= rRespD;
			rDataQ  <= rDataD;
		end
	end

	assign s_axi_bvalid = bValidQ;
	assign s_axi_bresp  = bRespQ;
	assign s_axi_rvalid = rValidQ;
	assign s_axi_rresp  = rRespQ;
	assign s_axi_rdata  = rDataQ;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	logic inRun;
	assign inRun = (stateQ == step_atten_pkg::PWR_RUN);

	property p_direct_follow;
		inRun && !serialMode && strobe |=> attenQ == $past(parWord);
	endproperty
	a_direct_follow: assert property (p_direct_follow) else $error("direct mode lag");

	property p_par_ignores_serial;
		inRun && !serialMode |=> $stable(shiftQ);
	endproperty
	a_par_ignores_serial: assert property (p_par_ignores_serial) else $error("shift in parallel");

	property p_serial_pass;
		inRun && serialMode && strobe |=> attenQ == shiftQ;
	endproperty
	a_serial_pass: assert property (p_serial_pass) else $error("latch not transparent");

	property p_sample_data;
		inRun && serialMode && clkRise |=> shiftQ[0] == $past(sData);
	endproperty
	a_sample_data: assert property (p_sample_data) else $error("data not sampled");

	property p_msb_first;
		inRun && serialMode && clkRise |=> shiftQ[5:1] == $past(shiftQ[4:0]);
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("shift order wrong");

	property p_latch_hold;
		inRun && !strobe ##1 !strobe |-> $stable(attenQ);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch not holding");

	property p_pwr_serial;
		lastWait && serialMode |=> inRun && attenQ == $past(parWord);
	endproperty
	a_pwr_serial: assert property (p_pwr_serial) else $error("serial power-up load");

	property p_pwr_preset8;
		lastWait && !serialMode && !strobe && presetSel == 2'h1 |=> attenQ == `SA_ATTEN_8DB;
	endproperty
	a_pwr_preset8: assert property (p_pwr_preset8) else $error("preset 8 dB wrong");

	property p_pwr_max;
		lastWait && !serialMode && !strobe && presetSel == 2'h3 |=> attenQ == `SA_ATTEN_MAX;
	endproperty
	a_pwr_max: assert property (p_pwr_max) else $error("preset max wrong");

	property p_pwr_direct;
		lastWait && !serialMode && strobe |=> attenQ == $past(parWord);
	endproperty
	a_pwr_direct: assert property (p_pwr_direct) else $error("direct power-up");

	c_serial_latch: cover property (inRun && serialMode && clkRise ##[1:200] strobe);
	c_preset: cover property (lastWait && !serialMode && !strobe);
	c_direct: cover property (inRun && !serialMode && strobe && $changed(parWord));
	c_reload: cover property (reloadReq);

endmodule // step_attenuator_control
`default_nettype wire

// ---- test/host_pin_driver.sv ----
/*
 Host controller model that drives the attenuator control pins.
 Assumes sys_clk from the bench; the serial clock keeps its own time.
*/
`timescale 1ns/1ps
`default_nettype none
module host_pin_driver (
	// Bench clock
	input  wire logic      sysClk,
	// Control pins
	output var  logic      modeSerial,
	output var  logic      strobe,
	output var  logic      serialData,
	output var  logic      serialClock,
	output var  logic [5:0] weights,
	output var  logic [1:0] preset
);
	// ----------------------------------------
	// Pin levels
	// ----------------------------------------
	initial begin
		modeSerial  = 1'b0;
		strobe      = 1'b1;
		serialData  = 1'b0;
		serialClock = 1'b0;
		weights     = 6'h00;
		preset      = 2'h0;
	end

	// levels change only at an edge
	task automatic set_pins(input logic m, input logic s, input logic [5:0] w,
		input logic [1:0] p);
		@(posedge sysClk);
		modeSerial <= m;
		strobe     <= s;
		weights    <= w;
		preset     <= p;
	endtask

	task automatic pulse_strobe();
		@(posedge sysClk);
		strobe <= 1'b1;
		repeat (8) @(posedge sysClk);
		strobe <= 1'b0;
		repeat (2) @(posedge sysClk);
	endtask

	// ----------------------------------------
	// Serial frame, 800 ns clock off the bench phase
	// ----------------------------------------
	// most significant bit first
	task automatic send_word(input logic [5:0] w);
		#130;
		for (int i = 5; i >= 0; i--) begin
			serialData = w[i];
			#400 serialClock = 1'b1;
			#400 serialClock = 1'b0;
		end
		// Released line must not keep the last bit
		serialData = ~w[0];
		// strobe waits after the last rise
		#400;
	endtask
endmodule // host_pin_driver
`default_nettype wire

// ---- test/step_attenuator_control_tb_top.sv ----
/*
 Self-checking bench of the step attenuator control block.
 Assumes the host model and the design's constants header.
*/
`timescale 1ns/1ps
`default_nettype none
`include "step_atten_defs.svh"
module step_attenuator_control_tb_top;
	logic        sysClk, rstn, modeSerial, strobe, serialData, serialClock;
	logic [5:0]  weights, attenState;
	logic [1:0]  preset, bResp, rResp;
	logic [3:0]  awAddr, arAddr, wStrb;
	logic [31:0] wData, rData;
	logic        awValid, awReady, wValid, wReady, bValid, bReady;
	logic        arValid, arReady, rValid, rReady;
	int          mismatches, checksDone;
	logic [11:0] rows [8] = '{{6'h01, 6'h01}, {6'h02, 6'h02}, {6'h04, 6'h04},
		{6'h08, 6'h08}, {6'h10, 6'h10}, {6'h20, 6'h20}, {6'h3F, 6'h3F}, {6'h2A, 6'h2A}};
	logic [5:0]  presetTab [4] = '{6'h00, 6'h10, 6'h20, 6'h3F};

	host_pin_driver host (.sysClk(sysClk), .modeSerial(modeSerial), .strobe(strobe),
		.serialData(serialData), .serialClock(serialClock), .weights(weights),
		.preset(preset));

	step_attenuator_control uut (.sys_clk(sysClk), .rstn(rstn), .modeSerial(modeSerial),
		.latch_strobe(strobe), .serialData(serialData), .serialClock(serialClock),
		.weight_half_db_bit(weights[0]), .weight_one_db_bit(weights[1]),
		.weight_two_db_bit(weights[2]), .weight_four_db_bit(weights[3]),
		.weight_eight_db_bit(weights[4]), .weight_sixteen_db_bit(weights[5]),
		.preset_select_msb(preset[1]), .preset_select_lsb(preset[0]),
		.attenState(attenState), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
		.s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
		.s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
		.s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
		.s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));

	initial begin
		sysClk = 1'b0;
		forever #50 sysClk = ~sysClk;
	end

	// ----------------------------------------
	// Compare and bus tasks
	// ----------------------------------------
	task automatic chk_atten(input logic [5:0] exp);
		checksDone++;
		if (attenState !== exp) begin
			mismatches++;
			$display("[FAIL] %0t attenuation %h, expected %h", $time, attenState, exp);
		end
	endtask
	task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t bus value %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_atten(input logic [5:0] exp);
		for (int i = 0; i < 40 && attenState !== exp; i++) @(posedge sysClk);
		chk_atten(exp);
	endtask
	// Checks every cycle, so a short glitch away from the held word is caught
	task automatic hold_atten(input logic [5:0] exp);
		repeat (12) begin
			@(posedge sysClk);
			if (attenState !== exp) break;
		end
		chk_atten(exp);
	endtask
	// Waits for the answer without a limit; only the watchdog ends a hang
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge sysClk);
		awAddr  <= a;
		wData   <= d;
		awValid <= 1'b1;
		wValid  <= 1'b1;
		bReady  <= 1'b1;
		do begin
			@(posedge sysClk);
			if (awValid && awReady) awValid <= 1'b0;
			if (wValid && wReady) wValid <= 1'b0;
		end while (!(bValid && bReady));
		r = bResp;
		bReady <= 1'b0;
	endtask
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge sysClk);
		arAddr  <= a;
		arValid <= 1'b1;
		rReady  <= 1'b1;
		do begin
			@(posedge sysClk);
			if (arValid && arReady) arValid <= 1'b0;
		end while (!(rValid && rReady));
		d = rData;
		r = rResp;
		rReady <= 1'b0;
	endtask
	// Pins settle before the power-up load is asked for
	task automatic reload();
		logic [1:0] r;
		repeat (8) @(posedge sysClk);
		axi_wr(`SA_REG_CTRL, 32'h0000_0001, r);
		chk_bus({30'h0, r}, {30'h0, `SA_RESP_OKAY});
	endtask
	task automatic end_test(input string n);
		$display("test %s finished, mismatches so far %0d", n, mismatches);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", checksDone, mismatches);
		if (mismatches == 0 && checksDone > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		{rstn, awValid, wValid, bReady, arValid, rReady} = '0;
		{awAddr, arAddr, wData} = '0;
		wStrb = 4'hF;
		mismatches = 0;
		checksDone = 0;
		repeat (6) @(posedge sysClk);
		chk_atten(6'h00);
		rstn <= 1'b1;
		repeat (10) @(posedge sysClk);
		foreach (rows[i]) begin
			host.set_pins(1'b0, 1'b1, rows[i][11:6], 2'h0);
			wait_atten(rows[i][5:0]);
		end
		end_test("direct");
		// Strobe goes low before the weights move
		host.set_pins(1'b0, 1'b0, 6'h2A, 2'h0);
		host.set_pins(1'b0, 1'b0, 6'h3F, 2'h0);
		hold_atten(6'h2A);
		host.pulse_strobe();
		wait_atten(6'h3F);
		end_test("latched");
		host.set_pins(1'b0, 1'b1, 6'h15, 2'h0);
		wait_atten(6'h15);
		host.send_word(6'h2A);
		hold_atten(6'h15);
		host.set_pins(1'b1, 1'b0, 6'h15, 2'h0);
		hold_atten(6'h15);
		axi_rd(`SA_REG_SHIFT, d, r);
		chk_bus(d, 32'h0000_0180);
		host.send_word(6'h2D);
		hold_atten(6'h15);
		host.pulse_strobe();
		wait_atten(6'h2D);
		host.set_pins(1'b1, 1'b1, 6'h15, 2'h0);
		host.send_word(6'h13);
		wait_atten(6'h13);
		host.set_pins(1'b1, 1'b0, 6'h15, 2'h0);
		host.send_word(6'h30);
		hold_atten(6'h13);
		end_test("serial");
		for (int p = 0; p < 4; p++) begin
			host.set_pins(1'b0, 1'b0, 6'h15, 2'(p));
			reload();
			wait_atten(presetTab[p]);
		end
		host.set_pins(1'b1, 1'b0, 6'h2B, 2'h0);
		reload();
		wait_atten(6'h2B);
		host.set_pins(1'b0, 1'b1, 6'h07, 2'h3);
		reload();
		hold_atten(6'h07);
		end_test("power-up");
		axi_rd(`SA_REG_ATTEN, d, r);
		chk_bus(d, 32'h0000_0007);
		axi_rd(4'hC, d, r);
		chk_bus({30'h0, r}, {30'h0, `SA_RESP_SLVERR});
		axi_wr(4'hC, 32'h0000_0001, r);
		chk_bus({30'h0, r}, {30'h0, `SA_RESP_SLVERR});
		axi_wr(`SA_REG_ATTEN, 32'h0000_003F, r);
		chk_bus({30'h0, r}, {30'h0, `SA_RESP_OKAY});
		hold_atten(6'h07);
		end_test("registers");
		give_verdict();
	end

	// Whole run is near 0.05 ms; this allows for slow waits
	initial begin
		#3_000_000;
		mismatches++;
		$display("[FAIL] %0t watchdog expired", $time);
		give_verdict();
	end
endmodule // step_attenuator_control_tb_top
`default_nettype wire
